// [rtl/dsw_top.sv]
// drive status word: assembly, parameter read ports and binary value objects
`timescale 1ns/1ps

module dsw_top
    import dsw_pkg::*;
#(
    parameter int NSRC = 3
) (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     arst_n_in,

    // drive state levels, asynchronous to clk_in
    input  wire logic                     run_cmd_in,
    input  wire logic                     emerg_run_in,
    input  wire logic                     second_ramp_in,
    input  wire logic                     config_state_in,
    input  wire logic                     alarm_in,
    input  wire logic                     running_in,
    input  wire logic                     enabled_in,
    input  wire logic                     forward_in,
    input  wire logic                     jog_in,
    input  wire logic                     remote_in,
    input  wire logic                     undervolt_in,
    input  wire logic                     fault_in,

    // parameter access, one lane per source
    input  wire logic [NSRC-1:0]          prm_req_in,
    input  wire logic [NSRC-1:0]          prm_wr_in,
    input  wire logic [NSRC*DSW_NUM_W-1:0] prm_num_in,
    output logic      [NSRC-1:0]          prm_ack_out,
    output logic      [NSRC-1:0]          prm_err_out,
    output logic      [NSRC*DSW_W-1:0]    prm_rdata_out,
    output logic      [NSRC-1:0]          prm_chg_out,

    // binary value object reads
    input  wire logic                     bv_req_in,
    input  wire logic [DSW_BV_IDX_W-1:0]  bv_idx_in,
    output logic                          bv_ack_out,
    output logic                          bv_err_out,
    output logic                          bv_val_out,

    // live word and readiness
    output logic      [DSW_W-1:0]         status_word_out,
    output logic                          word_valid_out
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        dsw_state_t                   st;
        logic [DSW_SETTLE_W-1:0]      settle_cnt;
        logic [DSW_W-1:0]             word;
        logic [NSRC-1:0]              ack;
        logic [NSRC-1:0]              err;
        logic [NSRC-1:0]              chg;
        logic [NSRC-1:0][DSW_W-1:0]   rdata;
        logic                         bv_ack;
        logic                         bv_err;
        logic                         bv_val;
    } dsw_regs_t;

    dsw_regs_t r_r;
    dsw_regs_t r_nxt;

    logic [DSW_NFLAGS-1:0] flags_raw;
    logic [DSW_NFLAGS-1:0] flags_sync;
    logic [DSW_W-1:0]      word_live;

    generate
        if (NSRC < 1 || NSRC > 8) begin : g_bad_nsrc
            $error("dsw_top: NSRC must lie between 1 and 8");
        end
        if (DSW_SETTLE_CYC < 1 || DSW_SETTLE_CYC > (1 << DSW_SETTLE_W)) begin : g_bad_settle
            $error("dsw_top: settle count does not fit its counter");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // input capture; flag order matches DSW_FLAG_POS

    assign flags_raw = {
        fault_in,
        undervolt_in,
        remote_in,
        jog_in,
        forward_in,
        enabled_in,
        running_in,
        alarm_in,
        config_state_in,
        second_ramp_in,
        emerg_run_in,
        run_cmd_in
    };

    dsw_sync #(
        .W (DSW_NFLAGS)
    ) u_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .async_in  (flags_raw),
        .sync_out  (flags_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // word assembly

    always_comb begin
        word_live = DSW_WORD_RST;
        for (int k = 0; k < DSW_NFLAGS; k++) begin
            // run, emergency-run, ramp, config, alarm, running
            // enabled, forward, jog, remote, undervoltage, fault
            word_live[DSW_FLAG_POS[k]] = flags_sync[k];
        end
        for (int b = 0; b < DSW_W; b++) begin
            // reserved positions are forced low whatever the flag table holds
            if (!dsw_bv_mapped(DSW_BV_IDX_W'(b))) begin
                word_live[b] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [DSW_NUM_W-1:0] num;
        logic                 good_rd;
        num     = '0;
        good_rd = 1'b0;
        r_nxt        = r_r;
        r_nxt.ack    = '0;
        r_nxt.err    = '0;
        r_nxt.bv_ack = 1'b0;
        r_nxt.bv_err = 1'b0;

        // the synchroniser still shows reset zeros for its first cycles,
        // so the word stays at its reset value until the pins are sampled
        case (r_r.st)
            DSW_ST_SETTLE: begin
                if (r_r.settle_cnt == DSW_SETTLE_LAST) begin
                    r_nxt.st = DSW_ST_RUN;
                end else begin
                    r_nxt.settle_cnt = r_r.settle_cnt + 1'b1;
                end
            end
            DSW_ST_RUN: begin
                r_nxt.word = word_live;
            end
            default: begin
                r_nxt.st         = DSW_ST_SETTLE;
                r_nxt.settle_cnt = '0;
                r_nxt.word       = DSW_WORD_RST;
            end
        endcase

        // every source sees the same registered word; writes never reach it
        for (int i = 0; i < NSRC; i++) begin
            num     = prm_num_in[i*DSW_NUM_W +: DSW_NUM_W];
            good_rd = prm_req_in[i] && !prm_wr_in[i] && (num == DSW_PARAM_NUM);
            if (prm_req_in[i]) begin
                r_nxt.ack[i] = 1'b1;
                if (good_rd) begin
                    r_nxt.rdata[i] = r_r.word;
                end else begin
                    r_nxt.err[i]   = 1'b1;
                    r_nxt.rdata[i] = '0;
                end
            end
            // a change in the same cycle as a read keeps the flag set
            r_nxt.chg[i] = (r_r.chg[i] && !good_rd) || (r_nxt.word != r_r.word);
        end

        // object n mirrors bit n; reserved or foreign objects are refused
        if (bv_req_in) begin
            r_nxt.bv_ack = 1'b1;
            if (dsw_bv_mapped(bv_idx_in)) begin
                r_nxt.bv_val = r_r.word[bv_idx_in[3:0]];
            end else begin
                r_nxt.bv_err = 1'b1;
                r_nxt.bv_val = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_r.st         <= DSW_ST_SETTLE;
            r_r.settle_cnt <= '0;
            r_r.word       <= DSW_WORD_RST;
            r_r.ack        <= '0;
            r_r.err        <= '0;
            r_r.chg        <= '0;
            r_r.rdata      <= '0;
            r_r.bv_ack     <= 1'b0;
            r_r.bv_err     <= 1'b0;
            r_r.bv_val     <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prm_ack_out     = r_r.ack;
    assign prm_err_out     = r_r.err;
    assign prm_rdata_out   = r_r.rdata;
    assign prm_chg_out     = r_r.chg;
    assign bv_ack_out      = r_r.bv_ack;
    assign bv_err_out      = r_r.bv_err;
    assign bv_val_out      = r_r.bv_val;
    assign status_word_out = r_r.word;
    assign word_valid_out  = (r_r.st == DSW_ST_RUN);

endmodule : dsw_top

// [rtl/dsw_pkg.sv]
// constants, types and decoders shared by the drive status word block
// What this block does
// - one read-only word, same for every source
// - bit 1 and object 1: run command
// - bit 2 and object 2: emergency-run mode
// - bit 5 and object 5: second ramp pair
// - bit 6 and object 6: configuration state
// - bit 7 and object 7: alarm state
// - bit 8 and object 8: motor running
// - bit 9 and object 9: enabled, ready
// - bit 10 and object 10: forward direction
// - bit 11 and object 11: jog active
// - bit 12 and object 12: remote mode
// - bit 13 and object 13: undervoltage
// - bit 15 and object 15: fault registered
package dsw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // word layout
    localparam int          DSW_W         = 16;
    localparam int          DSW_NFLAGS    = 12;
    localparam int          DSW_NUM_W     = 10;
    localparam logic [9:0]  DSW_PARAM_NUM = 10'h2a8;
    localparam logic [15:0] DSW_WORD_RST  = 16'h0000;
    localparam logic [15:0] DSW_RSVD_MASK = 16'h4019;

    localparam int DSW_BIT_RUN_CMD  = 1;
    localparam int DSW_BIT_EMERG    = 2;
    localparam int DSW_BIT_RAMP2    = 5;
    localparam int DSW_BIT_CONFIG   = 6;
    localparam int DSW_BIT_ALARM    = 7;
    localparam int DSW_BIT_RUNNING  = 8;
    localparam int DSW_BIT_ENABLED  = 9;
    localparam int DSW_BIT_FORWARD  = 10;
    localparam int DSW_BIT_JOG      = 11;
    localparam int DSW_BIT_REMOTE   = 12;
    localparam int DSW_BIT_UNDERV   = 13;
    localparam int DSW_BIT_FAULT    = 15;

    // flag k of the synchronised input vector lands on this bit position
    localparam int DSW_FLAG_POS [DSW_NFLAGS] = '{
        DSW_BIT_RUN_CMD, DSW_BIT_EMERG,   DSW_BIT_RAMP2,   DSW_BIT_CONFIG,
        DSW_BIT_ALARM,   DSW_BIT_RUNNING, DSW_BIT_ENABLED, DSW_BIT_FORWARD,
        DSW_BIT_JOG,     DSW_BIT_REMOTE,  DSW_BIT_UNDERV,  DSW_BIT_FAULT
    };

    ////////////////////////////////////////////////////////////////////////////
    // object addressing and timing
    localparam int DSW_BV_IDX_W = 5;

    localparam int DSW_CLK_NS    = 5;
    localparam int DSW_SETTLE_NS = 20;
    localparam int DSW_SETTLE_CYC = (DSW_SETTLE_NS + DSW_CLK_NS - 1) / DSW_CLK_NS;
    localparam int DSW_SETTLE_W  = 3;
    localparam logic [DSW_SETTLE_W-1:0] DSW_SETTLE_LAST = DSW_SETTLE_W'(DSW_SETTLE_CYC - 1);

    typedef enum logic [1:0] {
        DSW_ST_SETTLE = 2'b00,
        DSW_ST_RUN    = 2'b01
    } dsw_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // an object index or bit position that carries a documented status bit
    function automatic logic dsw_bv_mapped(input logic [DSW_BV_IDX_W-1:0] idx);
        logic ok;
        ok = 1'b0;
        if (idx[DSW_BV_IDX_W-1] == 1'b0) begin
            ok = ~DSW_RSVD_MASK[idx[3:0]];
        end
        return ok;
    endfunction : dsw_bv_mapped

endpackage : dsw_pkg

// [rtl/dsw_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module dsw_sync #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         arst_n_in,
    // asynchronous levels in, settled levels out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dsw_sync_regs_t;

    dsw_sync_regs_t r_r;
    dsw_sync_regs_t r_nxt;

    generate
        if (W < 1) begin : g_bad_w
            $error("dsw_sync: width must be at least one");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // s1 feeds only s2; a level is taken once the later two stages agree
    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = async_in;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        for (int i = 0; i < W; i++) begin
            if (r_r.s2[i] == r_r.s3[i]) begin
                r_nxt.q[i] = r_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign sync_out = r_r.q;

endmodule : dsw_sync

// [tb/dsw_monitor.sv]
// assertions on the drive status word ports
`timescale 1ns/1ps
module dsw_monitor
    import dsw_pkg::*;
#(
    parameter int NSRC = 3
) (
    // clock and reset
    input wire logic                  clk_in,
    input wire logic                  arst_n_in,
    // watched levels and requests
    input wire logic                  fault_in,
    input wire logic                  forward_in,
    input wire logic [NSRC-1:0]       prm_req_in,
    input wire logic [NSRC-1:0]       prm_wr_in,
    input wire logic [NSRC*10-1:0]    prm_num_in,
    input wire logic                  bv_req_in,
    input wire logic [DSW_BV_IDX_W-1:0] bv_idx_in,
    // watched answers
    input wire logic [NSRC-1:0]       prm_ack_out,
    input wire logic [NSRC-1:0]       prm_err_out,
    input wire logic [NSRC*DSW_W-1:0] prm_rdata_out,
    input wire logic                  bv_ack_out,
    input wire logic                  bv_err_out,
    input wire logic                  bv_val_out,
    input wire logic [DSW_W-1:0]      status_word_out,
    input wire logic                  word_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    logic [15:0] word_q;
    logic [4:0]  idx_q;
    always_ff @(posedge clk_in) begin
        word_q <= status_word_out;
        idx_q  <= bv_idx_in;
    end
    a_rsvd_zero: assert property ((status_word_out & 16'h4019) == 16'h0000)
        else $error("reserved bit set");
    a_good_read: assert property (prm_req_in[0] && !prm_wr_in[0] && prm_num_in[9:0] == 10'h2a8
        |=> !prm_err_out[0] && prm_rdata_out[15:0] == $past(status_word_out))
        else $error("read lane 0 wrong");
    a_bad_req: assert property (prm_req_in[0] && (prm_wr_in[0] || prm_num_in[9:0] != 10'h2a8)
        |=> prm_ack_out[0] && prm_err_out[0] && prm_rdata_out[15:0] == 16'h0000)
        else $error("refusal wrong");
    a_lane_same: assert property (prm_req_in[1:0] == 2'b11 && prm_wr_in[1:0] == 2'b00
        && prm_num_in[19:0] == {2{10'h2a8}}
        |=> prm_rdata_out[31:16] == prm_rdata_out[15:0])
        else $error("lanes disagree");
    a_ack_needs_req: assert property (!prm_req_in[2] |=> !prm_ack_out[2])
        else $error("ack without request");
    a_bv_mirror: assert property (bv_req_in && !bv_idx_in[4] && !DSW_RSVD_MASK[bv_idx_in[3:0]]
        |=> bv_ack_out && !bv_err_out && bv_val_out == word_q[idx_q[3:0]])
        else $error("object value wrong");
    a_bv_refuse: assert property (bv_req_in && (bv_idx_in[4] || DSW_RSVD_MASK[bv_idx_in[3:0]])
        |=> bv_ack_out && bv_err_out && !bv_val_out)
        else $error("reserved object served");
    a_fault_track: assert property ($rose(fault_in) && word_valid_out ##1 fault_in [*6]
        |-> status_word_out[15])
        else $error("fault bit late");
    a_fwd_clear: assert property ($fell(forward_in) && word_valid_out ##1 !forward_in [*6]
        |-> !status_word_out[10])
        else $error("forward bit stuck");
endmodule : dsw_monitor
bind dsw_top dsw_monitor #(.NSRC(NSRC)) u_mon (.clk_in, .arst_n_in, .fault_in, .forward_in,
    .prm_req_in, .prm_wr_in, .prm_num_in, .bv_req_in, .bv_idx_in, .prm_ack_out, .prm_err_out,
    .prm_rdata_out, .bv_ack_out, .bv_err_out, .bv_val_out, .status_word_out, .word_valid_out);

// [tb/dsw_client.sv]
// network client model issuing binary value object reads
`timescale 1ns/1ps
module dsw_client (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // bench command
    input  wire logic       go_in,
    input  wire logic [4:0] idx_in,
    // object read bus and captured answer
    output logic            bv_req_out,
    output logic [4:0]      bv_idx_out,
    input  wire logic       bv_ack_in,
    input  wire logic       bv_err_in,
    input  wire logic       bv_val_in,
    output logic            done_out,
    output logic            err_out,
    output logic            val_out
);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {bv_req_out, bv_idx_out, done_out, err_out, val_out} <= '0;
        end else begin
            bv_req_out <= go_in;
            // idle index toggles so a stale number never looks live
            bv_idx_out <= go_in ? idx_in : ~bv_idx_out;
            done_out   <= bv_ack_in;
            if (bv_ack_in) begin
                err_out <= bv_err_in;
                val_out <= bv_val_in;
            end
        end
    end
endmodule : dsw_client

// [tb/drive_status_word_bench.sv]
// self-checking bench for the drive status word
`timescale 1ns/1ps
module drive_status_word_bench;
    import dsw_pkg::*;
    logic        clk_in = 1'b0, arst_n_in = 1'b0, go = 1'b0, good1;
    logic [11:0] flags = '0;
    logic [2:0]  prm_req = '0, prm_wr = '0, prm_ack, prm_err, prm_chg;
    logic [29:0] prm_num = '0;
    logic [47:0] prm_rdata;
    logic        bv_req, bv_ack, bv_err, bv_val, c_done, c_err, c_val, word_valid;
    logic [4:0]  bv_idx, go_idx = '0;
    logic [15:0] word, exp_w, prev_w = 16'h0000;
    int          mismatches = 0, compares = 0, seed = 30594;
    dsw_top u_dut (.clk_in, .arst_n_in, .run_cmd_in(flags[0]), .emerg_run_in(flags[1]),
        .second_ramp_in(flags[2]), .config_state_in(flags[3]), .alarm_in(flags[4]),
        .running_in(flags[5]), .enabled_in(flags[6]), .forward_in(flags[7]),
        .jog_in(flags[8]), .remote_in(flags[9]), .undervolt_in(flags[10]),
        .fault_in(flags[11]), .prm_req_in(prm_req), .prm_wr_in(prm_wr), .prm_num_in(prm_num),
        .prm_ack_out(prm_ack), .prm_err_out(prm_err), .prm_rdata_out(prm_rdata),
        .prm_chg_out(prm_chg), .bv_req_in(bv_req), .bv_idx_in(bv_idx), .bv_ack_out(bv_ack),
        .bv_err_out(bv_err), .bv_val_out(bv_val), .status_word_out(word),
        .word_valid_out(word_valid));
    dsw_client u_cli (.clk_in, .arst_n_in, .go_in(go), .idx_in(go_idx), .bv_req_out(bv_req),
        .bv_idx_out(bv_idx), .bv_ack_in(bv_ack), .bv_err_in(bv_err), .bv_val_in(bv_val),
        .done_out(c_done), .err_out(c_err), .val_out(c_val));
    always #2.5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_word(input logic [11:0] f);
        int pos [12] = '{1, 2, 5, 6, 7, 8, 9, 10, 11, 12, 13, 15};
        exp_word = 16'h0000;
        for (int k = 0; k < 12; k++) exp_word[pos[k]] = f[k];
    endfunction : exp_word
    function automatic logic refused(input logic [4:0] i);
        return i[4] || i[3:0] == 4'h0 || i[3:0] == 4'h3 || i[3:0] == 4'h4 || i[3:0] == 4'he;
    endfunction : refused
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic close_out;
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic bv_read(input logic [4:0] i, input logic [15:0] w);
        @(posedge clk_in);
        go <= 1'b1;
        go_idx <= i;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (6) begin
            @(posedge clk_in);
            #1;
            if (c_done === 1'b1) break;
        end
        chk16({15'h0, c_done}, 16'h0001);
        chk16({14'h0, c_err, c_val}, {14'h0, refused(i), !refused(i) && w[i[3:0]]});
    endtask : bv_read
    initial begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int it = 0; it < 40; it++) begin
            @(posedge clk_in);
            flags <= (it == 0) ? 12'hfff : (it == 1) ? 12'h000 : 12'($random(seed));
            repeat (8) @(posedge clk_in);
            #1;
            exp_w = exp_word(flags);
            chk16(word, exp_w);
            chk16({15'h0, word_valid}, 16'h0001);
            // lane 0 was cleared by its last good read, so only a new word sets it
            chk16({15'h0, prm_chg[0]}, {15'h0, exp_w != prev_w});
            prev_w = exp_w;
            good1 = 1'($random(seed));
            @(posedge clk_in);
            prm_req <= 3'b111;
            prm_wr <= 3'b100;
            prm_num <= {10'h2a8, good1 ? 10'h2a8 : 10'h2a9, 10'h2a8};
            @(posedge clk_in);
            prm_req <= '0;
            #1;
            chk16(prm_rdata[15:0], exp_w);
            chk16(prm_rdata[31:16], good1 ? exp_w : 16'h0000);
            chk16(prm_rdata[47:32], 16'h0000);
            chk16({13'h0, prm_err}, {13'h0, 1'b1, !good1, 1'b0});
            chk16({13'h0, prm_ack}, {13'h0, 3'b111});
            // lane 2 only ever writes, so its change flag never clears
            chk16({14'h0, prm_chg[2], prm_chg[0]}, 16'h0002);
            for (int i = 0; i < 32; i++) bv_read(5'(i), exp_w);
        end
        close_out;
    end
    initial begin
        #100000;
        mismatches++;
        close_out;
    end
endmodule : drive_status_word_bench
